// ### common/sdram_cal_pkg.sv
// shared constants, types and helpers for the ddr command link
package sdram_cal_pkg;
	localparam int BANKS   = 8;
	localparam int BA_W    = 3;
	localparam int ADDR_W  = 15;
	localparam int DQ_W    = 8;
	localparam int TMR_W   = 5;
	// reference clock cycles per half period of the link clock
	localparam int CK_HALF = 4;
	// link timings, in link clock cycles
	localparam int T_RP_CK       = 6;
	localparam int T_MRD_CK      = 4;
	localparam int T_MOD_CK      = 12;
	localparam int T_MODE_CK     = (T_MOD_CK > T_MRD_CK) ? T_MOD_CK : T_MRD_CK;
	localparam int T_MPRR_CK     = 1;
	localparam int T_CCD_CK      = 4;
	localparam int T_AP_CK       = T_CCD_CK + T_RP_CK;
	localparam int T_CAL_WAIT_CK = 31;
	localparam int CAL_TAPS      = 4;
	// device read timing, in link clock cycles
	localparam int AL_CK         = 0;
	localparam int CL_CK         = 6;
	localparam int RL_MAX        = 16;
	// command pin codes {ras_b, cas_b, we_b}
	localparam logic [2:0] CMD_MRS = 3'h0;
	localparam logic [2:0] CMD_PRE = 3'h2;
	localparam logic [2:0] CMD_ACT = 3'h3;
	localparam logic [2:0] CMD_WR  = 3'h4;
	localparam logic [2:0] CMD_RD  = 3'h5;
	localparam logic [2:0] CMD_NOP = 3'h7;
	// address field positions
	localparam int AP_BIT     = 10;
	localparam int BC_BIT     = 12;
	localparam int NIB_BIT    = 2;
	localparam int MR3_EN_BIT = 2;
	localparam logic [BA_W-1:0] SEL_FIRST_MR = 3'h0;
	localparam logic [BA_W-1:0] SEL_THIRD_MR = 3'h3;
	localparam logic [1:0] LOC_PATTERN   = 2'h0;
	localparam logic [1:0] BURST_FIXED8  = 2'h0;
	localparam logic [1:0] BURST_OTF     = 2'h1;
	localparam logic [1:0] BURST_RST     = 2'h0;
	// beat i of the calibration pattern is bit i
	localparam logic [7:0] CAL_PATTERN   = 8'haa;
	localparam logic [3:0] BEATS_BL8     = 4'h8;
	localparam logic [3:0] BEATS_BC4     = 4'h4;

	typedef enum logic [2:0] {
		OP_ACT, OP_PRE, OP_PREA, OP_RD, OP_WR, OP_MRS, OP_CAL
	} user_op_t;

	typedef struct packed {
		logic       go;
		logic       bl8;
		logic       cal;
		logic       hi;
		logic [7:0] seed;
	} rd_slot_t;

	function automatic logic bl8_sel(input logic [1:0] burst,
		input logic chop_sel);
		return (burst == BURST_FIXED8) || ((burst == BURST_OTF) && chop_sel);
	endfunction

	function automatic logic [TMR_W-1:0] tmr_dec(input logic [TMR_W-1:0] t);
		return (t == '0) ? t : t - 1'b1;
	endfunction
endpackage

// ### common/ddr_link_if.sv
// command and data pins between controller and memory device
`timescale 1ns/1ps
interface ddr_link_if;
	import sdram_cal_pkg::*;
	logic              ck;
	logic              cs_b;
	logic              ras_b;
	logic              cas_b;
	logic              we_b;
	logic [BA_W-1:0]   ba;
	logic [ADDR_W-1:0] addr;
	logic [DQ_W-1:0]   dq_o;
	logic              dq_oe;
	logic              dqs_o;
	logic              dqs_oe;
	logic [DQ_W-1:0]   dq;
	logic              dqs;

	// undriven data lines settle low
	assign dq  = dq_oe ? dq_o : '0;
	assign dqs = dqs_oe ? dqs_o : 1'b0;

	modport ctrl (output ck, cs_b, ras_b, cas_b, we_b, ba, addr,
		input dq, dqs);
	modport mem (input ck, cs_b, ras_b, cas_b, we_b, ba, addr, dq,
		output dq_o, dq_oe, dqs_o, dqs_oe);
endinterface

// ### verilog/sync2.sv
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module sync2 #(
	parameter int W = 1
) (
	input  wire logic         ref_clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule

// ### verilog/sdram_cal_dev.sv
// memory device end: mode registers, bank state, read bursts
`timescale 1ns/1ps
module sdram_cal_dev #(
	parameter int AL       = sdram_cal_pkg::AL_CK,
	parameter int CL       = sdram_cal_pkg::CL_CK,
	parameter bit COPY_DQ0 = 1'b1
) (
	input  wire logic                     ref_clk,
	input  wire logic                     rst_b,
	ddr_link_if.mem                       link,
	output logic                          cal_mode,
	output logic                          protocol_err,
	output logic [sdram_cal_pkg::BANKS-1:0] bank_open
);
	import sdram_cal_pkg::*;
	localparam int RL_CK = AL + CL;
	localparam int SW    = 5 + BA_W + ADDR_W;

	logic [SW-1:0]     pins_s;
	logic              ck_s, ck_q_r, rise, fall, cs_b, valid;
	logic [2:0]        cmd;
	logic [BA_W-1:0]   ba;
	logic [ADDR_W-1:0] addr;
	logic [TMR_W-1:0]  pre_cnt_r [BANKS];
	logic [7:0]        row_lo_r  [BANKS];
	logic [1:0]        burst_r, loc_r;
	logic              err_nxt, push;
	rd_slot_t          slot_nxt;
	rd_slot_t          pipe_r [RL_MAX];
	logic [3:0]        left_r;
	logic [2:0]        idx_r;
	logic              cur_cal_r;
	logic [7:0]        seed_r;

	sync2 #(.W(SW)) u_sync (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.d       ({link.ck, link.cs_b, link.ras_b, link.cas_b, link.we_b,
			link.ba, link.addr}),
		.q       (pins_s)
	);
	assign {ck_s, cs_b, cmd, ba, addr} = pins_s;
	assign rise  = ck_s & ~ck_q_r;
	assign fall  = ~ck_s & ck_q_r;
	assign valid = rise & ~cs_b;

	always_ff @(posedge ref_clk) begin
		if (!rst_b)
			ck_q_r <= 1'b0;
		else
			ck_q_r <= ck_s;
	end

	function automatic logic [DQ_W-1:0] beat_data(input logic cal,
		input logic [7:0] seed, input logic [2:0] i);
		if (cal)
			return COPY_DQ0 ? {DQ_W{CAL_PATTERN[i]}}
				: {{(DQ_W-1){1'b0}}, CAL_PATTERN[i]};
		return seed + {5'h0, i};
	endfunction

	// command decode and protocol checks
	always_comb begin
		err_nxt  = 1'b0;
		push     = 1'b0;
		slot_nxt = '0;
		if (valid) begin
			case (cmd)
			CMD_ACT:
				err_nxt = cal_mode | bank_open[ba] | (pre_cnt_r[ba] != '0);
			CMD_RD: begin
				// bank and auto precharge ignored in calibration
				push = cal_mode | bank_open[ba];
				err_nxt = ~push;
				slot_nxt.go   = push;
				slot_nxt.bl8  = bl8_sel(burst_r, addr[BC_BIT]);
				slot_nxt.cal  = cal_mode;
				slot_nxt.hi   = ~slot_nxt.bl8 & addr[NIB_BIT];
				slot_nxt.seed = cal_mode ? 8'h00
					: row_lo_r[ba] ^ addr[7:0];
			end
			CMD_WR:
				err_nxt = cal_mode | ~bank_open[ba];
			CMD_MRS:
				err_nxt = (ba == SEL_THIRD_MR) && addr[MR3_EN_BIT]
					&& (addr[1:0] != LOC_PATTERN || bank_open != '0);
			CMD_PRE:
				err_nxt = cal_mode;
			default:
				err_nxt = cal_mode;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b)
			protocol_err <= 1'b0;
		else
			protocol_err <= err_nxt;
	end

	// mode registers
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			burst_r  <= BURST_RST;
			cal_mode <= 1'b0;
			loc_r    <= LOC_PATTERN;
		end else if (valid && cmd == CMD_MRS && !err_nxt) begin
			if (ba == SEL_FIRST_MR)
				burst_r <= addr[1:0];
			if (ba == SEL_THIRD_MR) begin
				cal_mode <= addr[MR3_EN_BIT];
				loc_r    <= addr[1:0];
			end
		end
	end

	// bank rows and precharge timers, counted in link clock cycles
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			bank_open <= '0;
			for (int b = 0; b < BANKS; b++) begin
				pre_cnt_r[b] <= '0;
				row_lo_r[b]  <= '0;
			end
		end else if (rise) begin
			for (int b = 0; b < BANKS; b++)
				pre_cnt_r[b] <= tmr_dec(pre_cnt_r[b]);
			if (valid && !err_nxt) begin
				if (cmd == CMD_ACT) begin
					bank_open[ba] <= 1'b1;
					row_lo_r[ba]  <= addr[7:0];
				end
				if (cmd == CMD_PRE) begin
					for (int b = 0; b < BANKS; b++) begin
						if (addr[AP_BIT] || ba == BA_W'(b)) begin
							bank_open[b] <= 1'b0;
							// a repeated precharge restarts the period
							pre_cnt_r[b] <= TMR_W'(T_RP_CK);
						end
					end
				end
				if ((cmd == CMD_RD || cmd == CMD_WR) && !cal_mode
					&& addr[AP_BIT]) begin
					bank_open[ba] <= 1'b0;
					pre_cnt_r[ba] <= TMR_W'(T_AP_CK);
				end
			end
		end
	end

	// read latency pipeline, one slot per link clock cycle
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			for (int i = 0; i < RL_MAX; i++)
				pipe_r[i] <= '0;
		end else if (rise) begin
			pipe_r[0] <= push ? slot_nxt : '0;
			for (int i = 1; i < RL_MAX; i++)
				pipe_r[i] <= pipe_r[i-1];
		end
	end

	// burst engine: one beat per link clock edge
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			left_r       <= '0;
			idx_r        <= '0;
			cur_cal_r    <= 1'b0;
			seed_r       <= '0;
			link.dq_o    <= '0;
			link.dq_oe   <= 1'b0;
			link.dqs_o   <= 1'b0;
			link.dqs_oe  <= 1'b0;
		end else if (rise && pipe_r[RL_CK-1].go) begin
			cur_cal_r   <= pipe_r[RL_CK-1].cal;
			seed_r      <= pipe_r[RL_CK-1].seed;
			idx_r       <= {pipe_r[RL_CK-1].hi, 2'b01};
			left_r      <= (pipe_r[RL_CK-1].bl8 ? BEATS_BL8 : BEATS_BC4)
				- 4'h1;
			link.dq_o   <= beat_data(pipe_r[RL_CK-1].cal,
				pipe_r[RL_CK-1].seed, {pipe_r[RL_CK-1].hi, 2'b00});
			link.dq_oe  <= 1'b1;
			link.dqs_o  <= 1'b1;
			link.dqs_oe <= 1'b1;
		end else if ((rise || fall) && left_r != '0) begin
			left_r      <= left_r - 4'h1;
			idx_r       <= idx_r + 3'h1;
			link.dq_o   <= beat_data(cur_cal_r, seed_r, idx_r);
			link.dqs_o  <= rise;
		end else if (rise || fall) begin
			link.dq_oe  <= 1'b0;
			link.dqs_o  <= 1'b0;
			link.dqs_oe <= 1'b0;
		end
	end
endmodule

// ### verilog/sdram_cal_ctrl.sv
// memory controller end: command issue, bank timing, read calibration
// How it works
// - precharge all and wait before calibration entry
// - third mode register enable, pattern location, redirects reads
// - wait spacing and update delay before reads
// - no writes while calibration mode enabled
// - calibration read: column low bits zero, eight beats
// - pattern bursts out after additive plus column latency
// - repeat calibration reads, stepping capture tap
// - recovery wait after last calibration burst
// - enable bit cleared returns device to array access
// - wait spacing and update delay after exit
// - activate opens addressed row in chosen bank
// - row stays open until bank precharged
// - precharge closes rows, reopen after precharge period
// - other bank access allowed during auto precharge
// - idle bank must be activated before access
// - repeated precharge restarts the precharge period
// - chop select low four beats, high eight
// - chop select never used as column address
// - eight beats when burst field fixed or selected
// - chop and auto precharge chosen per command
// - pattern alternates zero and one, zero first
// - line 0 carries pattern, others copy or zero
// - auto precharge ignored during calibration reads
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module sdram_cal_ctrl (
	input  wire logic                           ref_clk,
	input  wire logic                           rst_b,
	ddr_link_if.ctrl                            link,
	input  wire logic                           req,
	input  wire sdram_cal_pkg::user_op_t        op,
	input  wire logic [sdram_cal_pkg::BA_W-1:0] bank,
	input  wire logic [sdram_cal_pkg::ADDR_W-1:0] row,
	input  wire logic [9:0]                     col,
	input  wire logic                           chop_sel,
	input  wire logic                           auto_pre,
	output logic                                ack,
	output logic                                refused,
	output logic                                rd_valid,
	output logic [63:0]                         rd_data,
	output logic                                cal_busy,
	output logic                                cal_done,
	output logic                                cal_pass,
	output logic [1:0]                          cal_tap
);
	import sdram_cal_pkg::*;
	localparam int DIV_W = $clog2(CK_HALF);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CK_HALF - 1);
	localparam logic [1:0] TAP_LAST = 2'(CAL_TAPS - 1);

	typedef enum logic [3:0] {
		ST_IDLE, ST_PREA, ST_WAIT_RP, ST_MRS_ON, ST_WAIT_MOD, ST_CAL_RD,
		ST_CAL_CAP, ST_WAIT_MPRR, ST_MRS_OFF, ST_WAIT_EXIT
	} st_t;

	st_t               state_r, state_nxt;
	logic [DIV_W-1:0]  div_r;
	logic              ck_r, fall_en;
	logic [BANKS-1:0]  open_r;
	logic [TMR_W-1:0]  bank_tmr_r [BANKS];
	logic [TMR_W-1:0]  mode_tmr_r, col_tmr_r, wait_r, wait_val;
	logic              wait_ld, banks_quiet, bad, ok, take;
	logic [2:0]        iss_cmd;
	logic [BA_W-1:0]   iss_ba;
	logic [ADDR_W-1:0] iss_addr;
	logic [1:0]        burst_r;
	logic [DQ_W:0]     rx_s;
	logic              dqs_q_r, edge_now, cap;
	logic [3:0]        edge_dly_r;
	logic [3:0]        beat_r;
	logic              exp_bl8_r, done_r, pass_now;
	logic [63:0]       buf_r;
	logic [7:0]        cal_bits_r;

	// link clock made here by dividing the reference clock
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			div_r <= '0;
			ck_r  <= 1'b0;
		end else if (div_r == DIV_LAST) begin
			div_r <= '0;
			ck_r  <= ~ck_r;
		end else begin
			div_r <= div_r + 1'b1;
		end
	end
	// pins change on the falling link edge, half a cycle before sampling
	assign fall_en = (div_r == DIV_LAST) && ck_r;
	assign link.ck = ck_r;

	always_comb begin
		banks_quiet = (open_r == '0);
		for (int b = 0; b < BANKS; b++)
			if (bank_tmr_r[b] != '0)
				banks_quiet = 1'b0;
	end

	// request legality and timing against tracked bank state
	always_comb begin
		bad = ((op == OP_RD || op == OP_WR) && !open_r[bank])
			|| (op == OP_ACT && open_r[bank]);
		case (op)
		OP_ACT:  ok = (bank_tmr_r[bank] == '0);
		OP_RD:   ok = (col_tmr_r == '0);
		OP_WR:   ok = (col_tmr_r == '0);
		OP_MRS:  ok = banks_quiet;
		default: ok = 1'b1;
		endcase
		ok = ok && (mode_tmr_r == '0);
	end

	assign take    = fall_en && state_r == ST_IDLE && req && (bad || ok);
	assign ack     = take;
	assign cal_busy = (state_r != ST_IDLE);
	assign pass_now = exp_bl8_r ? (cal_bits_r == CAL_PATTERN)
		: (cal_bits_r[7:4] == CAL_PATTERN[3:0]);

	// command selection and sequencing, one step per link cycle
	always_comb begin
		state_nxt = state_r;
		iss_cmd   = CMD_NOP;
		iss_ba    = '0;
		iss_addr  = '0;
		wait_ld   = 1'b0;
		wait_val  = '0;
		if (fall_en) begin
			case (state_r)
			ST_IDLE: begin
				if (take && !bad) begin
					iss_ba   = bank;
					iss_addr = row;
					case (op)
					OP_ACT: iss_cmd = CMD_ACT;
					OP_PRE: iss_cmd = CMD_PRE;
					OP_PREA: begin
						iss_cmd = CMD_PRE;
						iss_addr[AP_BIT] = 1'b1;
					end
					OP_RD, OP_WR: begin
						iss_cmd  = (op == OP_RD) ? CMD_RD : CMD_WR;
						iss_addr = {2'b00, chop_sel, 1'b0, auto_pre, col};
						// chop select sits apart from column bits
						iss_addr[BC_BIT] = chop_sel;
					end
					OP_MRS: iss_cmd = CMD_MRS;
					default: state_nxt = ST_PREA;
					endcase
				end
			end
			ST_PREA: begin
				iss_cmd = CMD_PRE;
				iss_addr[AP_BIT] = 1'b1;
				state_nxt = ST_WAIT_RP;
			end
			ST_WAIT_RP:
				if (banks_quiet)
					state_nxt = ST_MRS_ON;
			ST_MRS_ON: begin
				iss_cmd = CMD_MRS;
				iss_ba  = SEL_THIRD_MR;
				iss_addr[MR3_EN_BIT] = 1'b1;
				iss_addr[1:0] = LOC_PATTERN;
				state_nxt = ST_WAIT_MOD;
			end
			ST_WAIT_MOD:
				if (mode_tmr_r == '0)
					state_nxt = ST_CAL_RD;
			ST_CAL_RD: begin
				// only reads, then the exit mode register set, are issued in calibration mode
				iss_cmd = CMD_RD;
				iss_addr[BC_BIT] = 1'b1;
				wait_ld  = 1'b1;
				wait_val = TMR_W'(T_CAL_WAIT_CK);
				state_nxt = ST_CAL_CAP;
			end
			ST_CAL_CAP: begin
				if (done_r || wait_r == '0) begin
					wait_ld  = 1'b1;
					wait_val = TMR_W'(T_MPRR_CK);
					if (done_r && pass_now)
						state_nxt = ST_WAIT_MPRR;
					else if (cal_tap == TAP_LAST)
						state_nxt = ST_WAIT_MPRR;
					else
						state_nxt = ST_CAL_RD;
				end
			end
			ST_WAIT_MPRR:
				if (wait_r == '0)
					state_nxt = ST_MRS_OFF;
			ST_MRS_OFF: begin
				iss_cmd = CMD_MRS;
				iss_ba  = SEL_THIRD_MR;
				state_nxt = ST_WAIT_EXIT;
			end
			ST_WAIT_EXIT:
				if (mode_tmr_r == '0)
					state_nxt = ST_IDLE;
			default:
				state_nxt = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			state_r <= ST_IDLE;
			refused <= 1'b0;
		end else begin
			state_r <= state_nxt;
			refused <= take && bad;
		end
	end

	// pins held until the next falling link edge
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			link.cs_b <= 1'b1;
			{link.ras_b, link.cas_b, link.we_b} <= CMD_NOP;
			link.ba   <= '0;
			link.addr <= '0;
		end else if (fall_en) begin
			link.cs_b <= (iss_cmd == CMD_NOP);
			{link.ras_b, link.cas_b, link.we_b} <= iss_cmd;
			link.ba   <= iss_ba;
			link.addr <= iss_addr;
		end
	end

	// bank bookkeeping from the issued command
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			open_r     <= '0;
			mode_tmr_r <= '0;
			col_tmr_r  <= '0;
			burst_r    <= BURST_RST;
			for (int b = 0; b < BANKS; b++)
				bank_tmr_r[b] <= '0;
		end else if (fall_en) begin
			mode_tmr_r <= tmr_dec(mode_tmr_r);
			col_tmr_r  <= tmr_dec(col_tmr_r);
			for (int b = 0; b < BANKS; b++)
				bank_tmr_r[b] <= tmr_dec(bank_tmr_r[b]);
			case (iss_cmd)
			CMD_ACT: open_r[iss_ba] <= 1'b1;
			CMD_PRE:
				for (int b = 0; b < BANKS; b++)
					if (iss_addr[AP_BIT] || iss_ba == BA_W'(b)) begin
						open_r[b]     <= 1'b0;
						bank_tmr_r[b] <= TMR_W'(T_RP_CK);
					end
			CMD_RD, CMD_WR: begin
				col_tmr_r <= TMR_W'(T_CCD_CK);
				if (iss_addr[AP_BIT] && state_r == ST_IDLE) begin
					open_r[iss_ba]     <= 1'b0;
					bank_tmr_r[iss_ba] <= TMR_W'(T_AP_CK);
				end
			end
			CMD_MRS: begin
				mode_tmr_r <= TMR_W'(T_MODE_CK);
				if (iss_ba == SEL_FIRST_MR)
					burst_r <= iss_addr[1:0];
			end
			default: ;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b)
			wait_r <= '0;
		else if (wait_ld)
			wait_r <= wait_val;
		else if (fall_en)
			wait_r <= tmr_dec(wait_r);
	end

	// read capture: strobe edges delayed by the selected tap
	sync2 #(.W(DQ_W + 1)) u_rx_sync (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.d       ({link.dqs, link.dq}),
		.q       (rx_s)
	);
	assign edge_now = rx_s[DQ_W] ^ dqs_q_r;
	assign cap      = (cal_tap == 2'h0) ? edge_now : edge_dly_r[cal_tap - 2'h1];

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			dqs_q_r    <= 1'b0;
			edge_dly_r <= '0;
		end else begin
			dqs_q_r    <= rx_s[DQ_W];
			edge_dly_r <= {edge_dly_r[2:0], edge_now};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			beat_r     <= '0;
			buf_r      <= '0;
			cal_bits_r <= '0;
			exp_bl8_r  <= 1'b1;
			done_r     <= 1'b0;
			rd_valid   <= 1'b0;
			rd_data    <= '0;
		end else begin
			rd_valid <= 1'b0;
			if (fall_en && iss_cmd == CMD_RD) begin
				exp_bl8_r <= bl8_sel(burst_r, iss_addr[BC_BIT]);
				done_r    <= 1'b0;
			end
			if (cap) begin
				buf_r      <= {rx_s[DQ_W-1:0], buf_r[63:8]};
				cal_bits_r <= {rx_s[0], cal_bits_r[7:1]};
				if (beat_r + 4'h1 == (exp_bl8_r ? BEATS_BL8 : BEATS_BC4)) begin
					beat_r   <= '0;
					done_r   <= 1'b1;
					rd_valid <= 1'b1;
					rd_data  <= {rx_s[DQ_W-1:0], buf_r[63:8]};
				end else begin
					beat_r <= beat_r + 4'h1;
				end
			end
		end
	end

	// calibration results
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			cal_tap  <= '0;
			cal_pass <= 1'b0;
			cal_done <= 1'b0;
		end else begin
			cal_done <= (state_r == ST_WAIT_EXIT) && (state_nxt == ST_IDLE);
			if (take && !bad && op == OP_CAL) begin
				cal_tap  <= '0;
				cal_pass <= 1'b0;
			end else if (state_r == ST_CAL_CAP && state_nxt != ST_CAL_CAP) begin
				if (done_r && pass_now)
					cal_pass <= 1'b1;
				else if (cal_tap != TAP_LAST)
					cal_tap <= cal_tap + 2'h1;
			end
		end
	end
endmodule

// ### test/sdram_cal_link_asserts.sv
// assertions on the ddr link between controller and device
`timescale 1ns/1ps
module sdram_cal_link_asserts (
	input wire logic                             ref_clk,
	input wire logic                             rst_b,
	input wire logic                             ck,
	input wire logic                             cs_b,
	input wire logic                             ras_b,
	input wire logic                             cas_b,
	input wire logic                             we_b,
	input wire logic [sdram_cal_pkg::BA_W-1:0]   ba,
	input wire logic [sdram_cal_pkg::ADDR_W-1:0] addr,
	input wire logic [sdram_cal_pkg::DQ_W-1:0]   dq,
	input wire logic                             dq_oe,
	input wire logic                             dqs
);
	import sdram_cal_pkg::*;
	localparam int RD_LO = (AL_CK + CL_CK) * 2 * CK_HALF;
	localparam int RD_HI = RD_LO + 4;
	logic             ck_q;
	logic             cal_r;
	logic [BANKS-1:0] open_r;
	int               pre_n;
	int               mrs_n;
	int               rd_n;
	int               age [BANKS];
	wire [2:0] cmd   = {ras_b, cas_b, we_b};
	wire       rise  = ck && !ck_q;
	// the device only looks at the pins on a ck rising edge
	wire       cmd_v = rise && !cs_b && cmd != CMD_NOP;
	wire       mode_register_set   = cmd_v && cmd == CMD_MRS;
	wire       mr3   = mode_register_set && ba == SEL_THIRD_MR;
	wire       act   = cmd_v && cmd == CMD_ACT;
	wire       pre   = cmd_v && cmd == CMD_PRE;
	wire       rd    = cmd_v && cmd == CMD_RD;
	wire       rw    = rd || (cmd_v && cmd == CMD_WR);
	wire       ap    = rw && addr[AP_BIT] && !cal_r;

	function automatic int up(input int v);
		return (v < 255) ? v + 1 : v;
	endfunction

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	always_ff @(posedge ref_clk)
		ck_q <= ck;
	always_ff @(posedge ref_clk) begin
		if (!rst_b)
			cal_r <= 1'h0;
		else if (mr3)
			cal_r <= addr[MR3_EN_BIT];
	end
	// link cycles since the last precharge, mode register set and read, saturating
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			pre_n <= 255;
			mrs_n <= 255;
			rd_n <= 255;
		end else if (rise) begin
			pre_n <= pre ? 1 : up(pre_n);
			mrs_n <= mode_register_set ? 1 : up(mrs_n);
			rd_n <= rd ? 1 : up(rd_n);
		end
	end
	// auto precharge starts T_CCD_CK link cycles after its column command
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			open_r <= '0;
			for (int i = 0; i < BANKS; i++)
				age[i] <= 255;
		end else if (rise) begin
			for (int i = 0; i < BANKS; i++) begin
				age[i] <= up(age[i]);
				if (act && int'(ba) == i)
					open_r[i] <= 1'h1;
				if (pre && (addr[AP_BIT] || int'(ba) == i)) begin
					open_r[i] <= 1'h0;
					age[i] <= 1;
				end
				if (ap && int'(ba) == i) begin
					open_r[i] <= 1'h0;
					age[i] <= 1 - T_CCD_CK;
				end
			end
		end
	end

	ck_high_a: assert property ($rose(ck) |-> ck [*4] ##1 !ck)
		else $error("link clock high phase wrong");
	pins_fall_a: assert property (
		!$stable({cs_b, cmd, ba, addr}) |-> $fell(ck))
		else $error("command pins moved off ck fall");
	cal_entry_a: assert property (mr3 && addr[MR3_EN_BIT] |->
		open_r == '0 && pre_n >= T_RP_CK) else $error("early cal entry");
	mode_gap_a: assert property (
		cmd_v && !mode_register_set |-> mrs_n >= T_MODE_CK) else $error("mode gap short");
	no_write_a: assert property (cmd_v && cmd == CMD_WR |-> !cal_r)
		else $error("write in calibration mode");
	cal_rd_a: assert property (rd && cal_r |->
		addr[2:0] == 3'h0 && addr[BC_BIT]) else $error("bad cal read");
	recover_a: assert property (mr3 && !addr[MR3_EN_BIT] && cal_r |->
		rd_n >= AL_CK + CL_CK + 4 + T_MPRR_CK) else $error("early cal exit");
	latency_a: assert property (rd |-> ##[RD_LO:RD_HI] $rose(dq_oe))
		else $error("read latency wrong");
	act_closed_a: assert property (act |-> !open_r[ba])
		else $error("activate to open bank");
	act_gap_a: assert property (act |-> age[ba] >= T_RP_CK)
		else $error("activate inside precharge period");
	access_open_a: assert property (rw && !cal_r |-> open_r[ba])
		else $error("column command to idle bank");
	copy_lines_a: assert property (
		dq_oe && cal_r |-> dq == {DQ_W{dq[0]}}) else $error("lines differ");
	pattern_a: assert property (
		dq_oe && cal_r && $changed(dqs) |-> dq[0] == !dqs)
		else $error("calibration pattern wrong");

	cover property (rd && cal_r);
	cover property (ap);
	cover property (mr3 && !addr[MR3_EN_BIT]);
endmodule

// ### test/sdram_calibration_read_cmds_bench.sv
// bench for controller and device joined over the ddr link
`timescale 1ns/1ps
module sdram_calibration_read_cmds_bench;
	import sdram_cal_pkg::*;
	logic              ref_clk;
	logic              rst_b;
	logic              req;
	user_op_t          op;
	logic [BA_W-1:0]   bank;
	logic [ADDR_W-1:0] row;
	logic [9:0]        col;
	logic              chop_sel;
	logic              auto_pre;
	logic              ack;
	logic              refused;
	logic              rd_valid;
	logic [63:0]       rd_data;
	logic              cal_done;
	logic              cal_busy;
	logic              cal_pass;
	logic [1:0]        cal_tap;
	logic              cal_mode;
	logic              protocol_err;
	logic [BANKS-1:0]  bank_open;
	logic              mode_seen = 1'h0;
	logic              err_seen = 1'h0;
	int                fail_count = 0;
	int                n_tests = 0;
	int                cyc = 0;

	ddr_link_if u_ddr_link_if ();
	sdram_cal_ctrl u_sdram_cal_ctrl (.ref_clk, .rst_b, .link(u_ddr_link_if),
		.req, .op, .bank, .row, .col, .chop_sel, .auto_pre, .ack, .refused,
		.rd_valid, .rd_data, .cal_busy, .cal_done, .cal_pass, .cal_tap);
	sdram_cal_dev u_sdram_cal_dev (.ref_clk, .rst_b, .link(u_ddr_link_if),
		.cal_mode, .protocol_err, .bank_open);
	sdram_cal_link_asserts u_sdram_cal_link_asserts (.ref_clk, .rst_b,
		.ck(u_ddr_link_if.ck), .cs_b(u_ddr_link_if.cs_b),
		.ras_b(u_ddr_link_if.ras_b), .cas_b(u_ddr_link_if.cas_b),
		.we_b(u_ddr_link_if.we_b), .ba(u_ddr_link_if.ba),
		.addr(u_ddr_link_if.addr), .dq(u_ddr_link_if.dq),
		.dq_oe(u_ddr_link_if.dq_oe), .dqs(u_ddr_link_if.dqs));

	initial begin
		ref_clk = 1'h0;
		forever #4 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		if (cal_mode === 1'h1)
			mode_seen <= 1'h1;
		if (protocol_err === 1'h1)
			err_seen <= 1'h1;
	end

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// f holds {refusal expected, auto precharge, eight beats}
	task automatic issue(input user_op_t o, input logic [2:0] b,
		input logic [14:0] r, input logic [9:0] c, input logic [2:0] f);
		int n;
		n = 0;
		@(posedge ref_clk);
		req <= 1'h1;
		op <= o;
		bank <= b;
		row <= r;
		col <= c;
		chop_sel <= f[0];
		auto_pre <= f[1];
		do begin
			@(negedge ref_clk);
			n++;
		end while (ack !== 1'h1 && n < 4000);
		chk(64'(ack), 64'h1);
		@(posedge ref_clk);
		req <= 1'h0;
		@(negedge ref_clk);
		chk(64'(refused), 64'(f[2]));
	endtask

	task automatic wait_hi(ref logic s);
		int n;
		n = 0;
		while (s !== 1'h1 && n < 5000) begin
			@(negedge ref_clk);
			n++;
		end
		chk(64'(s), 64'h1);
	endtask

	// array stand-in: beat i carries row byte xor column byte, plus i
	task automatic rd(input logic [2:0] b, input logic [14:0] r,
		input logic [9:0] c, input logic [1:0] f);
		logic [63:0] e;
		for (int i = 0; i < 8; i++)
			e[8*i +: 8] = (r[7:0] ^ c[7:0]) + 8'(i)
				+ (f[0] ? 8'h0 : {5'h0, c[2], 2'h0});
		issue(OP_RD, b, r, c, {1'h0, f});
		wait_hi(rd_valid);
		if (f[0])
			chk(rd_data, e);
		else
			chk(64'(rd_data[63:32]), 64'(e[31:0]));
	endtask

	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			fail_count++;
			end_of_test();
		end
	end

	initial begin
		rst_b = 1'h0;
		req = 1'h0;
		op = OP_ACT;
		bank = '0;
		row = '0;
		col = '0;
		chop_sel = 1'h1;
		auto_pre = 1'h0;
		repeat (8) @(posedge ref_clk);
		rst_b <= 1'h1;
		@(negedge ref_clk);
		chk(64'(cal_tap), 64'h0);
		chk(64'(bank_open), 64'h0);
		issue(OP_CAL, 3'h0, 15'h0, 10'h0, 3'h1);
		chk(64'(cal_busy), 64'h1);
		wait_hi(cal_done);
		chk(64'(cal_busy), 64'h0);
		chk(64'(cal_pass), 64'h1);
		chk(64'(mode_seen), 64'h1);
		chk(64'(cal_mode), 64'h0);
		issue(OP_MRS, SEL_FIRST_MR, 15'h1, 10'h0, 3'h1);
		issue(OP_ACT, 3'h2, 15'h1234, 10'h0, 3'h1);
		rd(3'h2, 15'h1234, 10'h010, 2'h1);
		chk(64'(bank_open[2]), 64'h1);
		issue(OP_ACT, 3'h2, 15'h0777, 10'h0, 3'h5);
		rd(3'h2, 15'h1234, 10'h018, 2'h0);
		rd(3'h2, 15'h1234, 10'h01c, 2'h0);
		issue(OP_RD, 3'h5, 15'h0, 10'h010, 3'h5);
		rd(3'h2, 15'h1234, 10'h020, 2'h3);
		repeat ((T_AP_CK + 4) * 2 * CK_HALF) @(negedge ref_clk);
		chk(64'(bank_open[2]), 64'h0);
		issue(OP_PRE, 3'h2, 15'h0, 10'h0, 3'h1);
		issue(OP_PRE, 3'h2, 15'h0, 10'h0, 3'h1);
		issue(OP_ACT, 3'h2, 15'h0f0f, 10'h0, 3'h1);
		issue(OP_ACT, 3'h6, 15'h0042, 10'h0, 3'h1);
		issue(OP_WR, 3'h6, 15'h0, 10'h008, 3'h2);
		issue(OP_PREA, 3'h0, 15'h0, 10'h0, 3'h1);
		repeat ((T_AP_CK + 4) * 2 * CK_HALF) @(negedge ref_clk);
		chk(64'(bank_open), 64'h0);
		chk(64'(err_seen), 64'h0);
		end_of_test();
	end
endmodule
